/* logic/host_bus_pkg.sv */
package host_bus_pkg;

    localparam int DATA_W     = 8;
    localparam int ADDR_W     = 8;
    localparam int DED_ADDR_W = 6;

    // bus style chosen from the address-latch pin
    typedef enum logic [1:0] {
        MODE_STROBE_DIR,
        MODE_SPLIT,
        MODE_MUXED
    } bus_mode_type;

    localparam bus_mode_type MODE_RST = MODE_SPLIT;

    localparam logic [DATA_W-1:0]     DATA_RST  = 8'h00;
    localparam logic [ADDR_W-1:0]     ADDR_RST  = 8'h00;
    localparam logic [DED_ADDR_W-1:0] DED_PULL  = 6'h00;
    localparam logic [ADDR_W-DED_ADDR_W-1:0] ADDR_HI_PAD = 2'h0;
    localparam logic [DATA_W-1:0]     OE_ALL    = 8'hff;
    localparam logic [DATA_W-1:0]     OE_NONE   = 8'h00;

    // host control pins, all active low except ale and the direction
    typedef struct packed {
        logic cs_n;
        logic dir_wr_n;
        logic strobe_rd_n;
        logic ale;
    } host_ctl_type;

    localparam host_ctl_type CTL_IDLE = 4'hf;

    // one register access towards the device core
    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } core_req_type;

    localparam core_req_type REQ_RST = 18'h00000;

endpackage

/* logic/host_bus_mode_select.sv */
`timescale 1ns/1ns
// Summary of operation
// - 8-bit host port, 8-bit address decode
// - small package: multiplexed style only
// - direction line plus single data strobe style
// - split read/write strobes, dedicated address pins
// - latch pin level or edge picks style
// - any latch pin edge forces multiplexed
// - multiplexed style held until hardware reset
// - unused dedicated address pulled low multiplexed
// - non-multiplexed: awake output held low
// - data strobe rising edge ends access
module host_bus_mode_select
    import host_bus_pkg::*;
#(
    parameter bit MUX_ONLY = 1'b0
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire host_ctl_type          ctl,
    input  wire logic [DED_ADDR_W-1:0] dedicated_addr_in,
    input  wire logic [DATA_W-1:0]     shared_addr_data_line_in,
    output logic      [DATA_W-1:0]     shared_addr_data_line_out,
    output logic      [DATA_W-1:0]     shared_addr_data_line_oe,
    input  wire logic                  external_awake_in,
    output logic                       awake_out,
    output bus_mode_type               mode_out,
    output core_req_type               core_req,
    input  wire logic [DATA_W-1:0]     reg_rdata
);

    localparam bus_mode_type MODE_INIT = MUX_ONLY ? MODE_MUXED : MODE_RST;

    host_ctl_type          prev_r;
    logic                  seen_r;
    bus_mode_type          mode_r;
    bus_mode_type          mode_nxt;
    logic [ADDR_W-1:0]     addr_lat_r;
    logic [DATA_W-1:0]     din_r;
    logic [DATA_W-1:0]     rdata_r;
    core_req_type          req_r;
    core_req_type          req_nxt;

    // style decode; seen_r marks the first sample after reset release
    wire ale_edge  = seen_r & (ctl.ale != prev_r.ale);
    wire is_muxed  = (mode_r == MODE_MUXED);
    wire is_strobe = (mode_r == MODE_STROBE_DIR);
    wire level_sel = ctl.ale;
    // the edge that selects multiplexed style already carries an address
    wire mux_now   = is_muxed | ale_edge;

    // next style: strap level once, then only an edge may change it
    always_comb begin
        mode_nxt = mode_r;
        if (MUX_ONLY) begin
            mode_nxt = MODE_MUXED;
        end else if (!seen_r) begin
            mode_nxt = level_sel ? MODE_STROBE_DIR : MODE_SPLIT;
        end else if (ale_edge) begin
            mode_nxt = MODE_MUXED;
        end
    end

    // strap capture and pin history; only the rst_n port reaches the reset branch
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= CTL_IDLE;
            seen_r <= 1'b0;
            mode_r <= MODE_INIT;
        end else begin
            prev_r <= ctl;
            seen_r <= 1'b1;
            mode_r <= mode_nxt;
        end
    end

    // dedicated pins read as low in multiplexed style
    wire [DED_ADDR_W-1:0] ded_eff = is_muxed ? DED_PULL : dedicated_addr_in;
    wire [ADDR_W-1:0] addr_sel = is_muxed ? addr_lat_r
                                          : {ADDR_HI_PAD, ded_eff};

    // awake pin passed through only in multiplexed style, held low otherwise
    assign awake_out = is_muxed & external_awake_in;

    // strobe edges; ends use the previous chip select so a host may
    // release select together with the strobe
    wire sel       = seen_r & ~ctl.cs_n;
    wire prev_sel  = seen_r & ~prev_r.cs_n;
    wire stb_fall  = prev_r.strobe_rd_n & ~ctl.strobe_rd_n;
    wire stb_rise  = ~prev_r.strobe_rd_n & ctl.strobe_rd_n;
    wire wr_rise   = ~prev_r.dir_wr_n & ctl.dir_wr_n;

    // direction plus single strobe
    wire dir_style_rd = is_strobe & sel & ctl.dir_wr_n & stb_fall;
    wire dir_style_wr = is_strobe & prev_sel & ~prev_r.dir_wr_n
                      & stb_rise;

    // split strobes, shared by the multiplexed style
    wire sp_rd = ~is_strobe & sel & stb_fall;
    wire sp_wr = ~is_strobe & prev_sel & wr_rise;

    // data lines driven only while the host reads
    wire read_active = sel & ~ctl.strobe_rd_n
                     & (is_strobe ? ctl.dir_wr_n : 1'b1);

    // write data is the sample before the closing edge, when it is stable
    always_comb begin
        req_nxt       = REQ_RST;
        req_nxt.rd    = dir_style_rd | sp_rd;
        req_nxt.wr    = dir_style_wr | sp_wr;
        req_nxt.addr  = addr_sel;
        req_nxt.wdata = din_r;
    end

    // address latch runs only in multiplexed style and on the latch pin edge that selects it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_lat_r <= ADDR_RST;
        end else if (mux_now && ctl.ale) begin
            addr_lat_r <= shared_addr_data_line_in;
        end
    end

    // data in sample and access request, one-cycle pulses
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            din_r <= DATA_RST;
            req_r <= REQ_RST;
        end else begin
            din_r <= shared_addr_data_line_in;
            req_r <= req_nxt;
        end
    end

    // core answers in the cycle of the read pulse
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= DATA_RST;
        end else if (req_r.rd) begin
            rdata_r <= reg_rdata;
        end
    end

    // outputs
    assign core_req                  = req_r;
    assign mode_out                  = mode_r;
    assign shared_addr_data_line_out = rdata_r;
    assign shared_addr_data_line_oe  = read_active ? OE_ALL : OE_NONE;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_mux_sticky: assert property (
        is_muxed |=> is_muxed)
        else $error("multiplexed style left without reset");

    chk_edge_forces_mux: assert property (
        ale_edge |=> is_muxed)
        else $error("latch pin edge did not select multiplexed");

    chk_level_strap: assert property (
        $rose(seen_r) && !MUX_ONLY |->
            mode_r == ($past(ctl.ale) ? MODE_STROBE_DIR : MODE_SPLIT))
        else $error("style does not match strapped latch level");

    chk_mux_only_pkg: assert property (
        MUX_ONLY |-> is_muxed)
        else $error("small variant left multiplexed style");

    chk_mux_addr_used: assert property (
        is_muxed && stb_fall && sel |=>
            core_req.rd && core_req.addr == $past(addr_lat_r))
        else $error("multiplexed read used wrong address");

    chk_awake_gated: assert property (
        !is_muxed |-> !awake_out)
        else $error("awake passed in non-multiplexed style");

    chk_dir_write_end: assert property (
        is_strobe && prev_sel && !prev_r.dir_wr_n && stb_rise |=>
            core_req.wr && core_req.wdata == $past(din_r))
        else $error("strobe rise did not end a write");

    chk_split_write: assert property (
        mode_r == MODE_SPLIT && prev_sel && wr_rise |=>
            core_req.wr &&
            core_req.addr == {ADDR_HI_PAD, $past(dedicated_addr_in)})
        else $error("split write missing or wrong address");

    chk_wr_pulse: assert property (
        core_req.wr |=> !core_req.wr)
        else $error("write request longer than one cycle");

    chk_dir_read_addr: assert property (
        dir_style_rd |=>
            core_req.rd &&
            core_req.addr == {ADDR_HI_PAD, $past(dedicated_addr_in)})
        else $error("strobe read missing or wrong address");

    chk_split_read: assert property (
        mode_r == MODE_SPLIT && sp_rd |=>
            core_req.rd &&
            core_req.addr == {ADDR_HI_PAD, $past(dedicated_addr_in)})
        else $error("split read missing or wrong address");

    // a write in strobe style must never fight the host on the lines
    chk_no_drive_write: assert property (
        is_strobe && !ctl.dir_wr_n |-> shared_addr_data_line_oe == OE_NONE)
        else $error("lines driven during strobe style write");

    chk_mux_latch: assert property (
        mux_now && ctl.ale |=>
            addr_lat_r == $past(shared_addr_data_line_in))
        else $error("address not latched while latch strobe high");

    chk_read_data: assert property (
        core_req.rd |=> shared_addr_data_line_out == $past(reg_rdata))
        else $error("read data not taken from core");

    cov_strobe_read: cover property (is_strobe && dir_style_rd);
    cov_strobe_write: cover property (is_strobe && dir_style_wr);
    cov_split_write: cover property (mode_r == MODE_SPLIT && sp_wr);
    cov_mux_entry: cover property (!is_muxed ##1 is_muxed);
    cov_mux_read: cover property (is_muxed && sp_rd);

endmodule // host_bus_mode_select

/* verif/host_cpu_model.sv */
`timescale 1ns/1ns
// host cpu: drives the pins, samples the wire on reads
module host_cpu_model
    import host_bus_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic [DATA_W-1:0]     wire_lvl,
    output host_ctl_type               ctl,
    output logic      [DED_ADDR_W-1:0] ded,
    output logic      [DATA_W-1:0]     lines
);
    initial begin
        ctl = CTL_IDLE;
        ded = 6'h00;
        lines = 8'h00;
    end

    // one access; ale is left alone at idle so no false edge
    task automatic access(input bus_mode_type m, input logic wr,
        input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge sys_clk);
        ded = (m == MODE_MUXED) ? 6'h3f : a[5:0];
        if (m == MODE_MUXED) begin
            ctl.ale = 1'b1;
            lines = a;
            @(negedge sys_clk);
            ctl.ale = 1'b0;
        end
        ctl.cs_n = 1'b0;
        if (m == MODE_STROBE_DIR) begin
            ctl.dir_wr_n = ~wr;
            ctl.strobe_rd_n = 1'b0;
        end else if (wr) begin
            ctl.dir_wr_n = 1'b0;
        end else begin
            ctl.strobe_rd_n = 1'b0;
        end
        lines = wr ? d : ~a; // released lines show a stray value
        repeat (3) @(negedge sys_clk);
        q = wire_lvl;
        ctl = {3'b111, ctl.ale};
        lines = ~lines;
        repeat (3) @(negedge sys_clk);
    endtask
endmodule // host_cpu_model

/* verif/host_bus_mode_select_tb_top.sv */
`timescale 1ns/1ns
module host_bus_mode_select_tb_top;
    import host_bus_pkg::*;
    logic         sys_clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         awake_out;
    host_ctl_type ctl;
    logic [5:0]   ded;
    logic [7:0]   lines, d_out, d_oe, wire_lvl, q;
    bus_mode_type mode;
    core_req_type req;
    core_req_type last = REQ_RST;
    int           num_errors = 0;
    int           checked = 0;

    always #4 sys_clk = ~sys_clk;
    // the wire follows whoever has it enabled
    assign wire_lvl = (d_oe == OE_ALL) ? d_out : lines;
    // last core request kept for later compares
    always @(posedge sys_clk) if (req.rd || req.wr) last <= req;

    host_bus_mode_select host_bus_mode_select_i (.sys_clk(sys_clk),
        .rst_n(rst_n), .ctl(ctl), .dedicated_addr_in(ded),
        .shared_addr_data_line_in(wire_lvl),
        .shared_addr_data_line_out(d_out),
        .shared_addr_data_line_oe(d_oe), .external_awake_in(1'b1),
        .awake_out(awake_out), .mode_out(mode), .core_req(req),
        .reg_rdata(8'ha7));
    host_cpu_model host_cpu_model_i (.sys_clk(sys_clk),
        .wire_lvl(wire_lvl), .ctl(ctl), .ded(ded), .lines(lines));

    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checked %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // strap level is set while reset is low
    task automatic do_reset(input logic a);
        rst_n = 1'b0;
        @(negedge sys_clk);
        host_cpu_model_i.ctl.ale = a;
        @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
    endtask

    task automatic t_split();
        do_reset(1'b0);
        chk(18'(mode), 18'(MODE_SPLIT));
        host_cpu_model_i.access(MODE_SPLIT, 1'b1, 8'h2a, 8'h5c, q);
        chk(last, {2'b01, 8'h2a, 8'h5c});
        host_cpu_model_i.access(MODE_SPLIT, 1'b0, 8'h13, 8'h00, q);
        chk(18'(q), 18'ha7);
        chk(18'(last.addr), 18'h13);
        chk(18'(awake_out), 18'h0);
        $display("split test done");
    endtask

    task automatic t_strobe();
        do_reset(1'b1);
        chk(18'(mode), 18'(MODE_STROBE_DIR));
        host_cpu_model_i.access(MODE_STROBE_DIR, 1'b1, 8'h05, 8'hc3, q);
        chk(last, {2'b01, 8'h05, 8'hc3});
        host_cpu_model_i.access(MODE_STROBE_DIR, 1'b0, 8'h31, 8'h00, q);
        chk(18'(q), 18'ha7);
        chk(18'(mode), 18'(MODE_STROBE_DIR));
        $display("strobe test done");
    endtask

    // ale pulse forces muxed, dedicated pins driven high are ignored
    task automatic t_mux();
        do_reset(1'b0);
        host_cpu_model_i.access(MODE_MUXED, 1'b1, 8'h9e, 8'h61, q);
        chk(18'(mode), 18'(MODE_MUXED));
        chk(last, {2'b01, 8'h9e, 8'h61});
        host_cpu_model_i.access(MODE_MUXED, 1'b0, 8'h44, 8'h00, q);
        chk(18'(q), 18'ha7);
        chk(18'(last.addr), 18'h44);
        chk(18'(awake_out), 18'h1);
        host_cpu_model_i.ctl.ale = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk(18'(mode), 18'(MODE_MUXED));
        do_reset(1'b0);
        chk(18'(mode), 18'(MODE_SPLIT));
        $display("mux test done");
    endtask

    initial begin
        t_split();
        t_strobe();
        t_mux();
        report_and_stop();
    end

    // a hang counts as a mismatch
    initial begin
        #100000;
        num_errors++;
        report_and_stop();
    end
endmodule // host_bus_mode_select_tb_top
